/* design/lasm_pkg.sv */
/*
 * lasm_pkg: register map, field positions, reset values and bus carriers
 * for the link alarm status masking block.
 * assumes an APB slave with 32-bit data and word-aligned registers.
 */
package lasm_pkg;
  // register indices as printed; byte address is four times the index
  localparam logic [15:0] LASM_IDX_TX_EN = 16'h9001;
  localparam logic [15:0] LASM_IDX_MASTER = 16'h9002;
  localparam logic [15:0] LASM_IDX_RX_EN = 16'h9003;
  // own registers: organisation identifier, fault status, irq status and mask
  localparam logic [15:0] LASM_IDX_ORG_ID = 16'h9000;
  localparam logic [15:0] LASM_IDX_FAULT = 16'h9004;
  localparam logic [15:0] LASM_IDX_IRQ_STAT = 16'h9005;
  localparam logic [15:0] LASM_IDX_IRQ_MASK = 16'h9006;
  localparam int LASM_ADDR_W = 18;
  localparam int LASM_REG_W = 16;
  // master control fields
  localparam int LASM_M_RX_BIT = 2;
  localparam int LASM_M_TX_BIT = 1;
  // reset values
  localparam logic [15:0] LASM_RX_EN_RST = 16'h0239;
  localparam logic [15:0] LASM_TX_EN_RST = 16'h03D9;
  localparam logic [15:0] LASM_MASTER_RST = 16'h0000;
  localparam logic [15:0] LASM_RX_WRITABLE = 16'h07FF;
  localparam logic [15:0] LASM_TX_WRITABLE = 16'h07FF;
  localparam logic [15:0] LASM_MASTER_WRITABLE = 16'h00FE;
  // interrupt status bits
  localparam int LASM_IRQ_W = 3;
  localparam int LASM_IRQ_RX = 0;
  localparam int LASM_IRQ_TX = 1;
  localparam int LASM_IRQ_ALARM = 2;

  // apb request carrier
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [LASM_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } lasm_apb_req_t;

  // fault inputs carrier
  typedef struct packed {
    logic [15:0] rx;
    logic [15:0] tx;
  } lasm_faults_t;
endpackage

/* design/lasm_top.sv */
/*
 * lasm_top: link alarm status masking, APB register file, alarm output
 * and a sticky interrupt block.
 * assumes fault inputs arrive from outside the mclk domain and are
 * synchronised here; APB master on mclk; rstn synchronous active low.
 */
// The APB slave port was left to the implementer.
`timescale 1ns/1ns
// Summary of operation
// - alarm output is active low and asserts on a possible link problem.
// - alarm asserts only for fault conditions software has enabled.
// - receive enable register at index 0x9003 selects receive faults.
// - transmit enable register at index 0x9001 selects transmit faults.
// - master control at index 0x9002 gates receive and transmit alarms.
// - all three control registers are sixteen bits; enable bits 10:0 and master bits 7:1 settable.
// - master bit 2 enables receive, bit 1 transmit; both reset to zero.
// - receive bits 9, 5, 4 default to one.
// - receive bits 3 and 0 always present, default one.
// - transmit bits 9, 8, 7 default to one.
// - transmit bits 6, 4, 3, 0 default to one.
// - device holds an organisation identifier readable by the host.
module lasm_top
  import lasm_pkg::*;
#(
  parameter logic [31:0] ORG_ID = 32'h00C0FFEE // arbitrary value
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [LASM_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // fault conditions from the transceiver
  input wire logic [15:0] rx_fault,
  input wire logic [15:0] tx_fault,
  // alarm and interrupt
  output logic link_alarm_output_n,
  output logic irq
);

  // decode helper: register index to byte address match
  function automatic logic hit(input logic [LASM_ADDR_W-1:0] a, input logic [15:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  lasm_apb_req_t req;
  lasm_faults_t s1, s2, s3, flt_r;
  logic [15:0] rx_en_r, tx_en_r, master_r;
  logic [LASM_IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_stat_nxt, ev;
  logic [31:0] prdata_r, rdata;
  logic alarm_r, rx_act, tx_act, alarm_nxt, prev_rx, prev_tx;
  logic wr, rd, h_rx, h_tx, h_m, h_id, h_f, h_is, h_im, mapped;

  // bus request and decode
  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  assign h_rx = hit(req.paddr, LASM_IDX_RX_EN);
  assign h_tx = hit(req.paddr, LASM_IDX_TX_EN);
  assign h_m = hit(req.paddr, LASM_IDX_MASTER);
  assign h_id = hit(req.paddr, LASM_IDX_ORG_ID);
  assign h_f = hit(req.paddr, LASM_IDX_FAULT);
  assign h_is = hit(req.paddr, LASM_IDX_IRQ_STAT);
  assign h_im = hit(req.paddr, LASM_IDX_IRQ_MASK);
  assign mapped = h_rx | h_tx | h_m | h_id | h_f | h_is | h_im;
  assign wr = req.psel & req.penable & req.pwrite & mapped;
  assign rd = req.psel & ~req.penable & ~req.pwrite;
  assign pready = 1'b1;
  assign pslverr = req.psel & req.penable & ~mapped;
  assign prdata = prdata_r;

  // read mux, registered in setup so data stands during access
  assign rdata = h_rx ? {16'h0000, rx_en_r} :
                 h_tx ? {16'h0000, tx_en_r} :
                 h_m ? {16'h0000, master_r} :
                 h_id ? ORG_ID :
                 h_f ? {flt_r.tx, flt_r.rx} :
                 h_is ? {29'h0, irq_stat_r} :
                 h_im ? {29'h0, irq_mask_r} : 32'h0000_0000;

  // fault synchronisers, change taken when stages two and three agree
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      flt_r <= '0;
    end else begin
      s1 <= '{rx: rx_fault, tx: tx_fault};
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) flt_r <= s3;
    end
  end

  // alarm combine
  assign rx_act = |(flt_r.rx & rx_en_r) & master_r[LASM_M_RX_BIT];
  assign tx_act = |(flt_r.tx & tx_en_r) & master_r[LASM_M_TX_BIT];
  assign alarm_nxt = rx_act | tx_act;
  assign link_alarm_output_n = ~alarm_r;

  // interrupt events: rising edges of the gated alarms
  assign ev = {alarm_nxt & ~alarm_r, tx_act & ~prev_tx, rx_act & ~prev_rx};
  assign irq_stat_nxt = (irq_stat_r & ~((wr & h_is) ? req.pwdata[LASM_IRQ_W-1:0] : '0)) | ev;
  assign irq = |(irq_stat_r & irq_mask_r);

  // control registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rx_en_r <= LASM_RX_EN_RST;
      tx_en_r <= LASM_TX_EN_RST;
      master_r <= LASM_MASTER_RST;
      irq_mask_r <= '0;
    end else if (wr) begin
      if (h_rx) rx_en_r <= req.pwdata[15:0] & LASM_RX_WRITABLE;
      if (h_tx) tx_en_r <= req.pwdata[15:0] & LASM_TX_WRITABLE;
      if (h_m) master_r <= req.pwdata[15:0] & LASM_MASTER_WRITABLE;
      if (h_im) irq_mask_r <= req.pwdata[LASM_IRQ_W-1:0];
    end
  end

  // status, alarm and read data
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      alarm_r <= 1'b0;
      prev_rx <= 1'b0;
      prev_tx <= 1'b0;
      irq_stat_r <= '0;
      prdata_r <= 32'h0000_0000;
    end else begin
      alarm_r <= alarm_nxt;
      prev_rx <= rx_act;
      prev_tx <= tx_act;
      irq_stat_r <= irq_stat_nxt; // set wins over clear
      if (rd) prdata_r <= rdata;
    end
  end

  // checks
  property p_alarm_low;
    @(posedge mclk) disable iff (!rstn) alarm_nxt |=> !link_alarm_output_n;
  endproperty
  a_alarm_low: assert property (p_alarm_low) else $error("alarm not driven low");
  property p_gated;
    @(posedge mclk) disable iff (!rstn)
      (master_r[LASM_M_RX_BIT] == 1'b0 && master_r[LASM_M_TX_BIT] == 1'b0) |=> link_alarm_output_n;
  endproperty
  a_gated: assert property (p_gated) else $error("alarm with global enables off");
  property p_rx_write;
    @(posedge mclk) disable iff (!rstn) (wr && h_rx) |=> rx_en_r == ($past(req.pwdata[15:0]) & LASM_RX_WRITABLE);
  endproperty
  a_rx_write: assert property (p_rx_write) else $error("receive enable not written");
  property p_tx_write;
    @(posedge mclk) disable iff (!rstn) (wr && h_tx) |=> tx_en_r == ($past(req.pwdata[15:0]) & LASM_TX_WRITABLE);
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("transmit enable not written");
  property p_master_write;
    @(posedge mclk) disable iff (!rstn)
      (wr && h_m) |=> master_r[LASM_M_RX_BIT:LASM_M_TX_BIT] == $past(req.pwdata[2:1]);
  endproperty
  a_master_write: assert property (p_master_write) else $error("master control not written");
  property p_width;
    @(posedge mclk) disable iff (!rstn) (rd && (h_rx || h_tx || h_m)) |=> prdata[31:16] == 16'h0000;
  endproperty
  a_width: assert property (p_width) else $error("control register wider than 16 bits");
  property p_reset_vals;
    @(posedge mclk) $rose(rstn) |-> rx_en_r == LASM_RX_EN_RST && tx_en_r == LASM_TX_EN_RST && master_r == 16'h0000;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");
  property p_id;
    @(posedge mclk) disable iff (!rstn) (rd && h_id) |=> prdata == ORG_ID;
  endproperty
  a_id: assert property (p_id) else $error("identifier read wrong");
  property p_combine;
    @(posedge mclk) disable iff (!rstn)
      ((|(flt_r.rx & rx_en_r)) && master_r[LASM_M_RX_BIT]) |=> ##1 !link_alarm_output_n || !$past(rx_act);
  endproperty
  a_combine: assert property (p_combine) else $error("enabled receive fault missed");

  // alarm combine checks: each gated path alone pulls the pin low
  // receive path active drives the pin low next cycle
  property p_rx_path;
    @(posedge mclk) disable iff (!rstn) rx_act |=> !link_alarm_output_n;
  endproperty
  a_rx_path: assert property (p_rx_path) else $error("receive alarm path missed");
  // transmit path active drives the pin low next cycle
  property p_tx_path;
    @(posedge mclk) disable iff (!rstn) tx_act |=> !link_alarm_output_n;
  endproperty
  a_tx_path: assert property (p_tx_path) else $error("transmit alarm path missed");
  // no synchronised fault, no alarm
  property p_quiet;
    @(posedge mclk) disable iff (!rstn) (flt_r == '0) |=> link_alarm_output_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("alarm without any fault");
  // receive faults that are not enabled never raise the alarm
  property p_rx_masked;
    @(posedge mclk) disable iff (!rstn) (!tx_act && (flt_r.rx & rx_en_r) == '0) |=> link_alarm_output_n;
  endproperty
  a_rx_masked: assert property (p_rx_masked) else $error("alarm from disabled receive fault");
  // transmit faults that are not enabled never raise the alarm
  property p_tx_masked;
    @(posedge mclk) disable iff (!rstn) (!rx_act && (flt_r.tx & tx_en_r) == '0) |=> link_alarm_output_n;
  endproperty
  a_tx_masked: assert property (p_tx_masked) else $error("alarm from disabled transmit fault");

  // register file checks: reserved bits stay zero, reads leave state alone
  // receive enable reserved bits stay clear
  property p_rx_reserved;
    @(posedge mclk) disable iff (!rstn) (rx_en_r & ~LASM_RX_WRITABLE) == '0;
  endproperty
  a_rx_reserved: assert property (p_rx_reserved) else $error("receive enable reserved bit set");
  // transmit enable reserved bits stay clear
  property p_tx_reserved;
    @(posedge mclk) disable iff (!rstn) (tx_en_r & ~LASM_TX_WRITABLE) == '0;
  endproperty
  a_tx_reserved: assert property (p_tx_reserved) else $error("transmit enable reserved bit set");
  // master control reserved bits stay clear
  property p_m_reserved;
    @(posedge mclk) disable iff (!rstn) (master_r & ~LASM_MASTER_WRITABLE) == '0;
  endproperty
  a_m_reserved: assert property (p_m_reserved) else $error("master reserved bit set");
  // a read access never disturbs the enables
  property p_read_clean;
    @(posedge mclk) disable iff (!rstn) (psel && penable && !pwrite) |=> $stable(rx_en_r) && $stable(tx_en_r);
  endproperty
  a_read_clean: assert property (p_read_clean) else $error("read changed an enable");
  // mask register takes the written value
  property p_mask_write;
    @(posedge mclk) disable iff (!rstn) (wr && h_im) |=> irq_mask_r == $past(req.pwdata[LASM_IRQ_W-1:0]);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("irq mask not written");

  // bus checks: zero wait states, error only on unmapped access
  // slave always ready
  property p_ready;
    @(posedge mclk) disable iff (!rstn) pready;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  // unmapped access flags an error
  property p_slverr;
    @(posedge mclk) disable iff (!rstn) (psel && penable && !mapped) |-> pslverr;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access without error");
  // mapped access never flags an error
  property p_no_slverr;
    @(posedge mclk) disable iff (!rstn) mapped |-> !pslverr;
  endproperty
  a_no_slverr: assert property (p_no_slverr) else $error("error on mapped access");
  // unmapped reads return zero
  property p_unmapped_rd;
    @(posedge mclk) disable iff (!rstn) (rd && !mapped) |=> prdata == '0;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");
  // read data stands until the next setup-cycle read
  property p_rd_stands;
    @(posedge mclk) disable iff (!rstn) !rd |=> $stable(prdata);
  endproperty
  a_rd_stands: assert property (p_rd_stands) else $error("read data changed outside setup");
  // fault status reads the synchronised levels
  property p_fault_rd;
    @(posedge mclk) disable iff (!rstn) (rd && h_f) |=> prdata == {$past(flt_r.tx), $past(flt_r.rx)};
  endproperty
  a_fault_rd: assert property (p_fault_rd) else $error("fault status read wrong");

  // synchroniser and interrupt checks
  // synchronised faults only move when stages two and three agree
  property p_sync_hold;
    @(posedge mclk) disable iff (!rstn) (s2 != s3) |=> flt_r == $past(flt_r);
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("fault taken before agreement");
  // receive alarm rise sets its sticky bit
  property p_rx_event;
    @(posedge mclk) disable iff (!rstn) $rose(rx_act) |=> irq_stat_r[LASM_IRQ_RX];
  endproperty
  a_rx_event: assert property (p_rx_event) else $error("receive event lost");
  // transmit alarm rise sets its sticky bit
  property p_tx_event;
    @(posedge mclk) disable iff (!rstn) $rose(tx_act) |=> irq_stat_r[LASM_IRQ_TX];
  endproperty
  a_tx_event: assert property (p_tx_event) else $error("transmit event lost");
  // alarm pin falling sets the alarm sticky bit
  property p_alarm_event;
    @(posedge mclk) disable iff (!rstn) $rose(alarm_r) |-> irq_stat_r[LASM_IRQ_ALARM];
  endproperty
  a_alarm_event: assert property (p_alarm_event) else $error("alarm event lost");
  // set wins over a clear in the same cycle
  property p_set_wins;
    @(posedge mclk) disable iff (!rstn) (ev[LASM_IRQ_RX] && wr && h_is) |=> irq_stat_r[LASM_IRQ_RX];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a new event");
  // sticky bit holds until written with a one
  property p_sticky;
    @(posedge mclk) disable iff (!rstn)
      (irq_stat_r[LASM_IRQ_ALARM] && !(wr && h_is && req.pwdata[LASM_IRQ_ALARM])) |=> irq_stat_r[LASM_IRQ_ALARM];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit lost");
  // irq high while an unmasked status bit is set
  property p_irq_on;
    @(posedge mclk) disable iff (!rstn) ((irq_stat_r & irq_mask_r) != '0) |-> irq;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");

  // covers for the main scenarios
  c_rx_alarm: cover property (@(posedge mclk) disable iff (!rstn) rx_act ##1 !link_alarm_output_n);
  c_tx_alarm: cover property (@(posedge mclk) disable iff (!rstn) tx_act ##1 !link_alarm_output_n);
  c_irq: cover property (@(posedge mclk) disable iff (!rstn) $rose(irq));
  c_clear: cover property (@(posedge mclk) disable iff (!rstn) (wr && h_is) ##1 !irq);
endmodule

/* sim/lasm_host_model.sv */
/* host model: apb master that drives register reads and writes.
   assumes one clock mclk shared with the block. */
`timescale 1ns/1ns
module lasm_host_model
  import lasm_pkg::*;
(
  // clock
  input wire logic mclk,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [LASM_ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
  end
  // one transfer: setup, access until pready, then release
  task automatic xfer(input logic w, input logic [LASM_ADDR_W-1:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a; // released lines must not keep the last value
    pwdata <= ~wd;
  endtask
endmodule

/* sim/link_alarm_status_masking_tb.sv */
/* testbench: register, alarm and interrupt checks through the host model.
   assumes lasm_pkg and lasm_top compiled first. */
`timescale 1ns/1ns
module link_alarm_status_masking_tb;
  import lasm_pkg::*;
  localparam logic [31:0] ORG = 32'h00001234; // arbitrary value
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, alarm_n, irq, err;
  logic [LASM_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic [15:0] rx_fault = 16'h0000;
  logic [15:0] tx_fault = 16'h0000;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  lasm_top #(.ORG_ID(ORG)) u_lasm_top(.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_fault(rx_fault), .tx_fault(tx_fault), .link_alarm_output_n(alarm_n), .irq(irq));
  lasm_host_model u_lasm_host_model(.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // clock and hang guard
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      stop_test();
    end
  end
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [15:0] i, logic [31:0] v);
    u_lasm_host_model.xfer(1'b1, {i, 2'b00}, v, d, err);
  endtask
  task automatic rdc(string nm, logic [15:0] i, logic [31:0] e);
    u_lasm_host_model.xfer(1'b0, {i, 2'b00}, 32'h0, d, err);
    chk(nm, e, d);
  endtask
  // wait for the fault path to settle, then check pin levels
  task automatic pins(logic a, logic q);
    repeat (8) @(posedge mclk);
    #1;
    chk("alarm_n", {31'h0, a}, {31'h0, alarm_n});
    chk("irq", {31'h0, q}, {31'h0, irq});
    @(posedge mclk);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    pins(1'b1, 1'b0);
    rdc("org_id", LASM_IDX_ORG_ID, ORG);
    rdc("tx_en", LASM_IDX_TX_EN, 32'h03D9);
    rdc("rx_en", LASM_IDX_RX_EN, 32'h0239);
    rdc("master", LASM_IDX_MASTER, 32'h0);
    wr(LASM_IDX_TX_EN, 32'hFFFFFFFF);
    rdc("tx_en", LASM_IDX_TX_EN, 32'h07FF);
    wr(LASM_IDX_RX_EN, 32'h0008);
    rdc("rx_en", LASM_IDX_RX_EN, 32'h0008);
    wr(LASM_IDX_MASTER, 32'h0004);
    rdc("master", LASM_IDX_MASTER, 32'h0004);
    rx_fault <= 16'h0001;
    pins(1'b1, 1'b0);
    rx_fault <= 16'h0008;
    pins(1'b0, 1'b0);
    wr(LASM_IDX_IRQ_MASK, 32'h0004);
    pins(1'b0, 1'b1);
    wr(LASM_IDX_MASTER, 32'h0002);
    pins(1'b1, 1'b1);
    tx_fault <= 16'h0001;
    pins(1'b0, 1'b1);
    wr(LASM_IDX_IRQ_STAT, 32'h0007);
    pins(1'b0, 1'b0);
    rdc("irq_stat", LASM_IDX_IRQ_STAT, 32'h0);
    u_lasm_host_model.xfer(1'b0, 18'h24040, 32'h0, d, err);
    chk("unmapped", 32'h1, {31'h0, err});
    chk("unmapped_rd", 32'h0, d);
    stop_test();
  end
endmodule
